// ===== acq_map.svh
/*
  register offsets, field positions, reset values and limits of the
  acquisition channel. assumes nothing; definitions only.
*/
`ifndef ACQ_MAP_SVH
`define ACQ_MAP_SVH

// register byte addresses
`define ACQ_REG_CTRL      8'h00
`define ACQ_REG_TUNE      8'h04
`define ACQ_REG_DECIM     8'h08
`define ACQ_REG_COEF_IDX  8'h0c
`define ACQ_REG_COEF_DATA 8'h10
`define ACQ_REG_XFER_LEN  8'h14
`define ACQ_REG_STATUS    8'h18
`define ACQ_REG_TSTAMP    8'h1c
`define ACQ_REG_CHAN_ID   8'h20

// control fields
`define ACQ_CTRL_SRC_LSB  0
`define ACQ_CTRL_MODE_BIT 2
`define ACQ_CTRL_FMT_BIT  3
`define ACQ_CTRL_RUN_BIT  4
`define ACQ_CTRL_GATE_BIT 5
`define ACQ_CTRL_W        6

// status fields
`define ACQ_STAT_OVF_BIT  0
`define ACQ_STAT_DONE_BIT 1
`define ACQ_STAT_META_BIT 2
`define ACQ_STAT_EMPTY_BIT 3
`define ACQ_STAT_FULL_BIT 4
`define ACQ_STAT_FILL_LSB 16

// widths, limits and reset values
`define ACQ_SAMPLE_W      12
`define ACQ_TUNE_W        32
`define ACQ_COEF_W        16
`define ACQ_DECIM_W       18
`define ACQ_DECIM_MIN     18'h00002
`define ACQ_DECIM_MAX     18'h20000
`define ACQ_IQ_W          48
`define ACQ_CTRL_RST      6'h00
`define ACQ_DECIM_RST     18'h00002
`define ACQ_XFER_LEN_RST  16'h0100
`define ACQ_COEF_RST      16'h4000

`endif

// ===== acq_pkg.sv
/*
  types shared by the acquisition channel and its downconverter.
  assumes acq_map.svh for widths elsewhere.
*/
package acq_pkg;
  typedef enum logic [1:0] {
    ACQ_SRC_ADC0 = 2'b00,
    ACQ_SRC_ADC1 = 2'b01,
    ACQ_SRC_TEST = 2'b10
  } acq_src_t;

  // gray codes along data -> id -> stamp -> length
  typedef enum logic [1:0] {
    ACQ_OUT_DATA = 2'b00,
    ACQ_OUT_ID = 2'b01,
    ACQ_OUT_TS = 2'b11,
    ACQ_OUT_LEN = 2'b10
  } acq_out_t;
endpackage

// ===== acq_ddc_if.sv
/*
  configuration and stream signals between the channel and its
  downconverter. assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "acq_map.svh"

interface acq_ddc_if;
  logic [`ACQ_SAMPLE_W-1:0] sample;
  logic [`ACQ_TUNE_W-1:0] tune;
  logic [`ACQ_DECIM_W-1:0] decim;
  logic fmt16;
  logic run;
  logic coef_we;
  logic [3:0] coef_addr;
  logic [`ACQ_COEF_W-1:0] coef_data;
  logic out_valid;
  logic [`ACQ_IQ_W-1:0] out_iq;

  modport ctl (output sample, tune, decim, fmt16, run, coef_we, coef_addr, coef_data,
               input out_valid, out_iq);
  modport ddc (input sample, tune, decim, fmt16, run, coef_we, coef_addr, coef_data,
               output out_valid, out_iq);
endinterface

// ===== acq_ddc.sv
/*
  digital downconverter: nco mixer and coefficient-weighted decimator.
  assumes decim is already held within 2..131072 by the channel.
*/
`timescale 1ns/1ps
`include "acq_map.svh"

module acq_ddc
  import acq_pkg::*;
#(
  parameter int TAPS = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // channel side
  acq_ddc_if.ddc dif
);
  localparam int ACC_W = 58;
  localparam logic [ACC_W-1:0] ACC_ZERO = '0;

  if (TAPS != 16) begin : g_chk
    $error("acq_ddc: coefficient index is four bits, TAPS must be 16");
  end

  // coarse cosine table, 16 phases, signed 12 bit
  function automatic logic signed [11:0] cos_lut(input logic [3:0] p);
    logic signed [11:0] v;
    v = 12'sh000;
    unique case (p)
      4'h0: v = 12'sh7ff; 4'h1: v = 12'sh764; 4'h2: v = 12'sh5a8; 4'h3: v = 12'sh30f;
      4'h4: v = 12'sh000; 4'h5: v = 12'shcf1; 4'h6: v = 12'sha58; 4'h7: v = 12'sh89c;
      4'h8: v = 12'sh801; 4'h9: v = 12'sh89c; 4'ha: v = 12'sha58; 4'hb: v = 12'shcf1;
      4'hc: v = 12'sh000; 4'hd: v = 12'sh30f; 4'he: v = 12'sh5a8; 4'hf: v = 12'sh764;
    endcase
    return v;
  endfunction

  logic [`ACQ_TUNE_W-1:0] phase_q;
  logic [`ACQ_COEF_W-1:0] coef_q [TAPS];
  logic [`ACQ_DECIM_W-1:0] cnt_q;
  logic signed [ACC_W-1:0] acc_i_q, acc_q_q;
  logic signed [23:0] mix_i, mix_q;
  logic signed [39:0] prod_i, prod_q;
  logic signed [ACC_W-1:0] sum_i, sum_q;
  logic last;

  // phase increment per sample, frequency = tune / 2^32 * fs
  always_ff @(posedge clock) begin
    if (sys_rst) phase_q <= '0;
    else if (dif.run) phase_q <= phase_q + dif.tune;
  end

  // per-converter coefficient set, default is a flat boxcar
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int k = 0; k < TAPS; k++) coef_q[k] <= `ACQ_COEF_RST;
    end else if (dif.coef_we) begin
      coef_q[dif.coef_addr] <= dif.coef_data;
    end
  end

  // sample taken as signed 12 bit
  always_comb begin
    mix_i = $signed(dif.sample) * cos_lut(phase_q[31:28]);
    mix_q = -($signed(dif.sample) * cos_lut(phase_q[31:28] - 4'h4));
    prod_i = mix_i * $signed(coef_q[cnt_q[3:0]]);
    prod_q = mix_q * $signed(coef_q[cnt_q[3:0]]);
    sum_i = acc_i_q + ACC_W'(prod_i);
    sum_q = acc_q_q + ACC_W'(prod_q);
  end
  assign last = (cnt_q == dif.decim - 18'h00001);

  // integrate and dump over decim samples, one output per window
  always_ff @(posedge clock) begin
    if (sys_rst || !dif.run) begin
      cnt_q <= '0;
      acc_i_q <= ACC_ZERO;
      acc_q_q <= ACC_ZERO;
    end else begin
      cnt_q <= last ? '0 : cnt_q + 18'h00001;
      acc_i_q <= last ? ACC_ZERO : sum_i;
      acc_q_q <= last ? ACC_ZERO : sum_q;
    end
  end

  // complex result at fs/decim, 24+24 or 16+16 bits; wraps, no saturation
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dif.out_valid <= 1'b0;
      dif.out_iq <= '0;
    end else begin
      dif.out_valid <= dif.run && last;
      if (dif.run && last) begin
        dif.out_iq <= dif.fmt16 ? {16'h0000, sum_i[47:32], sum_q[47:32]} : {sum_i[47:24], sum_q[47:24]};
      end
    end
  end
endmodule

// ===== acq_channel.sv
/*
  acquisition channel: source select, downconverter, memory bank in fifo
  or transient-capture mode, and a gate-driven dma path with metadata.
  assumes converter samples and the gate are synchronous to clock, and
  that the dma sink may stall through dma_ready.
*/
`timescale 1ns/1ps
`include "acq_map.svh"

module acq_channel
  import acq_pkg::*;
#(
  parameter logic [7:0] CHAN_ID = 8'h01,
  parameter int BANK_NUM = 1,
  parameter int DEPTH = 1024
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // converter samples and acquisition gate
  input wire logic [`ACQ_SAMPLE_W-1:0] adc0_data,
  input wire logic [`ACQ_SAMPLE_W-1:0] adc1_data,
  input wire logic acq_gate,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // dma stream toward host
  output logic [`ACQ_IQ_W-1:0] dma_data,
  output logic dma_meta,
  output logic dma_valid,
  input wire logic dma_ready,
  // memory bank this channel owns
  output logic [1:0] mem_bank
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  // factory channels may only claim banks 1 and 2
  if (BANK_NUM < 1 || BANK_NUM > 2) begin : g_bank_chk
    $error("acq_channel: BANK_NUM must be 1 or 2");
  end
  if (DEPTH < 4 || DEPTH > 32768 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("acq_channel: DEPTH must be a power of two from 4 to 32768");
  end

  acq_ddc_if dif ();

  //////////////////////////////////////////////////////////////////////////////
  // registers
  //////////////////////////////////////////////////////////////////////////////
  logic [`ACQ_CTRL_W-1:0] ctrl_q;
  logic [`ACQ_TUNE_W-1:0] tune_q;
  logic [`ACQ_DECIM_W-1:0] decim_q;
  logic [3:0] coef_idx_q;
  logic [15:0] xfer_len_q;
  logic ovf_q, done_q;
  logic wr_ctrl, wr_tune, wr_decim, wr_cidx, wr_cdata, wr_xlen, wr_stat;
  logic [`ACQ_DECIM_W-1:0] decim_w;
  acq_src_t src;
  logic capture, fmt16, run, gate_mode;

  assign wr_ctrl = reg_wr && reg_addr == `ACQ_REG_CTRL;
  assign wr_tune = reg_wr && reg_addr == `ACQ_REG_TUNE;
  assign wr_decim = reg_wr && reg_addr == `ACQ_REG_DECIM;
  assign wr_cidx = reg_wr && reg_addr == `ACQ_REG_COEF_IDX;
  assign wr_cdata = reg_wr && reg_addr == `ACQ_REG_COEF_DATA;
  assign wr_xlen = reg_wr && reg_addr == `ACQ_REG_XFER_LEN;
  assign wr_stat = reg_wr && reg_addr == `ACQ_REG_STATUS;

  assign src = acq_src_t'(ctrl_q[`ACQ_CTRL_SRC_LSB +: 2]);
  assign capture = ctrl_q[`ACQ_CTRL_MODE_BIT];
  assign fmt16 = ctrl_q[`ACQ_CTRL_FMT_BIT];
  assign run = ctrl_q[`ACQ_CTRL_RUN_BIT];
  assign gate_mode = ctrl_q[`ACQ_CTRL_GATE_BIT];
  assign decim_w = reg_wdata[`ACQ_DECIM_W-1:0];

  // control word: source, bank mode, output format, run, gate mode
  always_ff @(posedge clock) begin
    if (sys_rst) ctrl_q <= `ACQ_CTRL_RST;
    else if (wr_ctrl) ctrl_q <= reg_wdata[`ACQ_CTRL_W-1:0];
  end

  // tuning word per downconverter
  always_ff @(posedge clock) begin
    if (sys_rst) tune_q <= '0;
    else if (wr_tune) tune_q <= reg_wdata;
  end

  // decimation clamped into 2..131072 so the decimator never sees 0 or 1
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      decim_q <= `ACQ_DECIM_RST;
    end else if (wr_decim) begin
      if (reg_wdata[31:`ACQ_DECIM_W] != '0 || decim_w > `ACQ_DECIM_MAX) decim_q <= `ACQ_DECIM_MAX;
      else if (decim_w < `ACQ_DECIM_MIN) decim_q <= `ACQ_DECIM_MIN;
      else decim_q <= decim_w;
    end
  end

  // coefficient index steps after each data write, so a set loads as a burst
  always_ff @(posedge clock) begin
    if (sys_rst) coef_idx_q <= '0;
    else if (wr_cidx) coef_idx_q <= reg_wdata[3:0];
    else if (wr_cdata) coef_idx_q <= coef_idx_q + 4'h1;
  end

  // preset transfer length, used only outside gate mode
  always_ff @(posedge clock) begin
    if (sys_rst) xfer_len_q <= `ACQ_XFER_LEN_RST;
    else if (wr_xlen) xfer_len_q <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // source selection and downconverter
  //////////////////////////////////////////////////////////////////////////////
  logic [`ACQ_SAMPLE_W-1:0] test_q, sample;

  // test generator: a ramp, easy to recognise after decimation
  always_ff @(posedge clock) begin
    if (sys_rst) test_q <= '0;
    else test_q <= test_q + 12'h001;
  end

  // either converter may feed any number of channels
  always_comb begin
    unique case (src)
      ACQ_SRC_ADC0: sample = adc0_data;
      ACQ_SRC_ADC1: sample = adc1_data;
      ACQ_SRC_TEST: sample = test_q;
      default: sample = test_q;
    endcase
  end

  assign dif.sample = sample;
  assign dif.tune = tune_q;
  assign dif.decim = decim_q;
  assign dif.fmt16 = fmt16;
  assign dif.run = run;
  assign dif.coef_we = wr_cdata;
  assign dif.coef_addr = coef_idx_q;
  assign dif.coef_data = reg_wdata[`ACQ_COEF_W-1:0];

  acq_ddc #(.TAPS(16)) u_ddc (
    .clock(clock),
    .sys_rst(sys_rst),
    .dif(dif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // memory bank
  //////////////////////////////////////////////////////////////////////////////
  logic [`ACQ_IQ_W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [AW:0] fill_q;
  logic gate_q, gate_fall, allow, push, pop, full, empty;
  logic [31:0] stamp_q;

  assign full = fill_q == DEPTH_CNT;
  assign empty = fill_q == '0;
  assign gate_fall = gate_q && !acq_gate;

  // capture mode freezes after a finished record until it is read out
  assign allow = run && (!gate_mode || acq_gate) && !(capture && done_q);
  assign push = dif.out_valid && allow && !full;

  // sample counter for time stamps, one count per converter sample
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stamp_q <= '0;
      gate_q <= 1'b0;
    end else begin
      stamp_q <= stamp_q + 32'h00000001;
      gate_q <= acq_gate;
    end
  end

  always_ff @(posedge clock) begin
    if (push) mem[wr_ptr_q] <= dif.out_iq;
  end

  // pointers and fill level
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop) fill_q <= fill_q + 1'b1;
      else if (pop && !push) fill_q <= fill_q - 1'b1;
    end
  end

  // overflow in fifo mode: a lost word sets it and the set beats a clear
  always_ff @(posedge clock) begin
    if (sys_rst) ovf_q <= 1'b0;
    else if (dif.out_valid && allow && full && !capture) ovf_q <= 1'b1;
    else if (wr_stat && reg_wdata[`ACQ_STAT_OVF_BIT]) ovf_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // transfer tracking
  //////////////////////////////////////////////////////////////////////////////
  logic in_xfer_q, meta_pend_q, xfer_end, meta_done;
  logic [15:0] wcnt_q, wcnt_nx, meta_len_q, rcnt_q;
  logic [31:0] ts_q, meta_ts_q;
  acq_out_t st_q;

  assign wcnt_nx = push ? wcnt_q + 16'h0001 : wcnt_q;
  // gate mode: length is whatever the gate held; else the preset count
  assign xfer_end = (in_xfer_q || push) &&
                    (gate_mode ? gate_fall : (push && wcnt_nx == xfer_len_q));

  // open a transfer on its first word, latching the sample-exact stamp
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      in_xfer_q <= 1'b0;
      wcnt_q <= '0;
      ts_q <= '0;
    end else if (xfer_end) begin
      in_xfer_q <= 1'b0;
      wcnt_q <= '0;
    end else if (push) begin
      in_xfer_q <= 1'b1;
      wcnt_q <= wcnt_nx;
      if (!in_xfer_q) ts_q <= stamp_q;
    end
  end

  // closed transfer waits for its metadata; a new close beats the old clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_pend_q <= 1'b0;
      meta_len_q <= '0;
      meta_ts_q <= '0;
    end else if (xfer_end && !(meta_pend_q && !meta_done)) begin
      meta_pend_q <= 1'b1;
      meta_len_q <= wcnt_nx;
      meta_ts_q <= (in_xfer_q ? ts_q : stamp_q);
    end else if (meta_done) begin
      meta_pend_q <= 1'b0;
    end
  end

  // capture record done when the transfer closes, released once read out
  always_ff @(posedge clock) begin
    if (sys_rst) done_q <= 1'b0;
    else if (capture && xfer_end) done_q <= 1'b1;
    else if (done_q && !meta_pend_q && empty) done_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // dma output: data words, then id, stamp, length
  //////////////////////////////////////////////////////////////////////////////
  logic at_meta;

  assign at_meta = meta_pend_q && rcnt_q == meta_len_q;
  assign pop = st_q == ACQ_OUT_DATA && !at_meta && !empty && dma_ready;
  assign meta_done = st_q == ACQ_OUT_LEN && dma_ready;

  // words read in the current transfer; metadata may not pass its own data
  always_ff @(posedge clock) begin
    if (sys_rst || meta_done) rcnt_q <= '0;
    else if (pop) rcnt_q <= rcnt_q + 16'h0001;
  end

  // metadata packet sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= ACQ_OUT_DATA;
    end else begin
      unique case (st_q)
        ACQ_OUT_DATA: if (at_meta) st_q <= ACQ_OUT_ID;
        ACQ_OUT_ID: if (dma_ready) st_q <= ACQ_OUT_TS;
        ACQ_OUT_TS: if (dma_ready) st_q <= ACQ_OUT_LEN;
        ACQ_OUT_LEN: if (dma_ready) st_q <= ACQ_OUT_DATA;
      endcase
    end
  end

  always_comb begin
    dma_meta = st_q != ACQ_OUT_DATA;
    dma_valid = dma_meta || (!at_meta && !empty);
    unique case (st_q)
      ACQ_OUT_DATA: dma_data = mem[rd_ptr_q];
      ACQ_OUT_ID: dma_data = {40'h0000000000, CHAN_ID};
      ACQ_OUT_TS: dma_data = {16'h0000, meta_ts_q};
      ACQ_OUT_LEN: dma_data = {32'h00000000, meta_len_q};
    endcase
  end

  assign mem_bank = 2'(BANK_NUM);

  //////////////////////////////////////////////////////////////////////////////
  // register readback, one cycle after the read strobe
  //////////////////////////////////////////////////////////////////////////////
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[`ACQ_STAT_OVF_BIT] = ovf_q;
    status[`ACQ_STAT_DONE_BIT] = done_q;
    status[`ACQ_STAT_META_BIT] = meta_pend_q;
    status[`ACQ_STAT_EMPTY_BIT] = empty;
    status[`ACQ_STAT_FULL_BIT] = full;
    status[`ACQ_STAT_FILL_LSB +: 16] = 16'(fill_q);
  end

  // unmapped addresses and idle cycles read zero
  always_ff @(posedge clock) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        `ACQ_REG_CTRL: reg_rdata <= {26'h0000000, ctrl_q};
        `ACQ_REG_TUNE: reg_rdata <= tune_q;
        `ACQ_REG_DECIM: reg_rdata <= {14'h0000, decim_q};
        `ACQ_REG_COEF_IDX: reg_rdata <= {28'h0000000, coef_idx_q};
        `ACQ_REG_XFER_LEN: reg_rdata <= {16'h0000, xfer_len_q};
        `ACQ_REG_STATUS: reg_rdata <= status;
        `ACQ_REG_TSTAMP: reg_rdata <= stamp_q;
        `ACQ_REG_CHAN_ID: reg_rdata <= {24'h000000, CHAN_ID};
        default: reg_rdata <= '0;
      endcase
    end
  end
endmodule

// ===== acq_channel_monitor.sv
/*
  port checker for acq_channel: register readback, dma hold and metadata order.
  assumes it is bound to every acq_channel instance and shares its clock.
*/
`timescale 1ns/1ps
module acq_channel_monitor #(
  parameter logic [7:0] CHAN_ID = 8'h01,
  parameter int BANK_NUM = 1,
  parameter int DEPTH = 1024
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // dma stream and bank
  input wire logic [47:0] dma_data,
  input wire logic dma_meta,
  input wire logic dma_valid,
  input wire logic dma_ready,
  input wire logic [1:0] mem_bank
);
  logic [1:0] meta_q;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // counts accepted metadata words; clears whenever data words flow
  always_ff @(posedge clock) begin
    if (sys_rst || !dma_meta) begin
      meta_q <= 2'h0;
    end else if (dma_valid && dma_ready) begin
      meta_q <= meta_q + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  a_bank_fixed: assert property (mem_bank == BANK_NUM[1:0])
    else $error("bank output moved");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_chan_id_read: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == {24'h0, CHAN_ID})
    else $error("channel id read wrong");
  a_tune_back: assert property (reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("tuning readback wrong");
  a_decim_clamp: assert property (reg_wr && reg_addr == 8'h08 ##1 reg_rd && reg_addr == 8'h08
    |=> reg_rdata == (($past(reg_wdata, 2) < 32'h2) ? 32'h2 :
    ($past(reg_wdata, 2) > 32'h20000) ? 32'h20000 : $past(reg_wdata, 2)))
    else $error("decimation clamp wrong");
  a_word_hold: assert property (dma_valid && !dma_ready |=> dma_valid && $stable(dma_data) && $stable(dma_meta))
    else $error("dma word dropped before accept");
  a_meta_first: assert property ($rose(dma_meta) |-> dma_data == {40'h0, CHAN_ID})
    else $error("packet does not open with id");
  a_meta_stamp: assert property (dma_meta && meta_q == 2'h1 |-> dma_data[47:32] == 16'h0)
    else $error("stamp word upper bits set");
  a_meta_three: assert property (dma_meta && dma_valid && dma_ready && meta_q == 2'h2 |=> !dma_meta)
    else $error("packet longer than three words");
endmodule

bind acq_channel acq_channel_monitor #(.CHAN_ID(CHAN_ID), .BANK_NUM(BANK_NUM), .DEPTH(DEPTH)) mon_u (.clock,
  .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dma_data, .dma_meta, .dma_valid, .dma_ready,
  .mem_bank);

// ===== acq_sink_model.sv
/*
  far side of the channel: two converters and a dma sink.
  assumes one clock; the bench decides when the sink stalls.
*/
`timescale 1ns/1ps
module acq_sink_model (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // bench control
  input wire logic stall_en,
  // converter samples
  output logic [11:0] adc0_data,
  output logic [11:0] adc1_data,
  // dma handshake
  output logic dma_ready
);
  int seed = 32'hbe1e36ec;
  // quiet outputs until the first edge
  initial begin
    adc0_data = 12'h0;
    adc1_data = 12'h0;
    dma_ready = 1'b0;
  end
  // new 12-bit samples every clock; ready is random so the sink is both prompt and slow
  always @(posedge clock) begin
    adc0_data <= 12'($random(seed));
    adc1_data <= 12'($random(seed));
    dma_ready <= !sys_rst && !stall_en && $random(seed) % 2 != 0;
  end
endmodule

// ===== acq_channel_tb_top.sv
/*
  self-checking bench for acq_channel: registers, gate and preset transfers.
  assumes acq_map.svh, the design and the sink model are compiled first.
*/
`timescale 1ns/1ps
`include "acq_map.svh"
module acq_channel_tb_top;
  localparam logic [7:0] CID = 8'h5a;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic acq_gate = 1'b0;
  logic stall = 1'b0;
  logic f16 = 1'b0;
  logic [11:0] adc0_data;
  logic [11:0] adc1_data;
  logic [31:0] reg_rdata;
  logic [47:0] dma_data;
  logic dma_meta;
  logic dma_valid;
  logic dma_ready;
  logic [1:0] mem_bank;
  int errors = 0;
  int n_tests = 0;
  int seed = 32'hbe1e36ec;
  int nd;
  logic [47:0] mq[$];
  logic [7:0] ra[7] = '{8'h00, 8'h08, 8'h14, 8'h04, 8'h20, 8'h10, 8'h24};
  logic [31:0] re[7] = '{32'h0, 32'h2, 32'h100, 32'h0, 32'h5a, 32'h0, 32'h0};
  logic [31:0] dv[8] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h20000, 32'h20001, 32'hffffffff, 32'h1ffff};
  logic [5:0] ctl[5] = '{6'h30, 6'h39, 6'h32, 6'h10, 6'h14};
  int dec[5] = '{2, 4, 3, 3, 2};
  ////////////////////////////////////////////////////////////
  acq_channel #(.CHAN_ID(CID), .BANK_NUM(2), .DEPTH(64)) dut_u (.clock, .sys_rst, .adc0_data, .adc1_data,
    .acq_gate, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dma_data, .dma_meta, .dma_valid,
    .dma_ready, .mem_bank);
  acq_sink_model mdl_u (.clock, .sys_rst, .stall_en(stall), .adc0_data, .adc1_data, .dma_ready);
  // 200 MHz clock
  initial begin
    forever #2.5 clock = ~clock;
  end
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // write then read the same register back to back
  task wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask
  function automatic logic [31:0] clamp(input logic [31:0] v);
    return (v < 32'h2) ? 32'h2 : (v > 32'h20000) ? 32'h20000 : v;
  endfunction
  // reference model of the stream: count data words, queue the packet that follows
  always @(posedge clock) begin
    if (!sys_rst && dma_valid && dma_ready) begin
      if (dma_meta) begin
        mq.push_back(dma_data);
      end else if (mq.size() < 3) begin
        nd++;
        if (f16) begin
          chk(dma_data[47:32], 48'h0);
        end
        // tuning is zero after every reset, so the oscillator sits at dc and q stays zero
        chk(f16 ? dma_data[15:0] : dma_data[23:0], 48'h0);
      end
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [31:0] t0;
    int k;
    int i;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      rd(ra[i], r);
      chk(r, re[i]);
    end
    chk(mem_bank, 2);
    for (i = 0; i < 8; i++) begin
      wr_rd(`ACQ_REG_DECIM, dv[i], r);
      chk(r, clamp(dv[i]));
    end
    for (i = 0; i < 4; i++) begin
      t0 = $random(seed);
      wr_rd(`ACQ_REG_TUNE, t0, r);
      chk(r, t0);
      wr_rd(`ACQ_REG_CTRL, i, r);
      chk(r, i);
    end
    wr_rd(`ACQ_REG_XFER_LEN, 32'h0, r);
    chk(r, 1);
    // sixteen coefficient loads wrap the index back to zero
    wr_rd(`ACQ_REG_COEF_IDX, 32'h0, r);
    for (i = 0; i < 16; i++) begin
      wr_rd(`ACQ_REG_COEF_DATA, 32'($random(seed)) & 32'hffff, r);
      chk(r, 0);
    end
    rd(`ACQ_REG_COEF_IDX, r);
    chk(r, 0);
    // three gate-length transfers, one preset fifo transfer, one stalled capture
    for (k = 0; k < 5; k++) begin
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      wr_rd(`ACQ_REG_DECIM, dec[k], r);
      wr_rd(`ACQ_REG_XFER_LEN, 32'h5, r);
      rd(`ACQ_REG_TSTAMP, t0);
      stall <= (k == 4);
      f16 = ctl[k][3];
      nd = 0;
      mq = {};
      wr_rd(`ACQ_REG_CTRL, 32'(ctl[k]), r);
      if (ctl[k][5]) begin
        // the gate moves on a rising edge like every other design input
        @(posedge clock);
        acq_gate <= 1'b1;
        repeat (40) @(posedge clock);
        acq_gate <= 1'b0;
      end
      if (k == 4) begin
        repeat (60) @(posedge clock);
        rd(`ACQ_REG_STATUS, r);
        chk(r[1], 1);
        stall <= 1'b0;
      end
      for (i = 0; i < 5000 && mq.size() < 3; i++) begin
        @(posedge clock);
      end
      if (mq.size() < 3) begin
        errors++;
        tally_and_finish;
      end
      chk(mq[0], {40'h0, CID});
      chk(mq[2], 48'(nd));
      chk(mq[1] > t0 && mq[1] <= t0 + 64, 1);
      if (ctl[k][5]) begin
        chk(nd >= 40 / dec[k] - 2 && nd <= 40 / dec[k] + 2, 1);
      end else begin
        chk(48'(nd), 5);
      end
    end
    // fifo overflow behind a stalled sink; the flag stays set until written with one
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    stall <= 1'b1;
    wr_rd(`ACQ_REG_CTRL, 32'h10, r);
    repeat (200) @(posedge clock);
    rd(`ACQ_REG_STATUS, r);
    chk(r[0], 1);
    chk(r[4], 1);
    chk(r[31:16], 64);
    wr_rd(`ACQ_REG_CTRL, 32'h0, r);
    wr_rd(`ACQ_REG_STATUS, 32'h1, r);
    chk(r[0], 0);
    chk(r[31:16], 64);
    stall <= 1'b0;
    tally_and_finish;
  end
endmodule
